// File: hdl/psc_core.sv
// Processor state, privilege level, stack choice and space code control.
//
// How it works
// - Sync op waits for bus cycles and external FP operand accesses.
// - Sync op never waits for the floating-point register pipeline.
// - Outside halt the state is normal or exception processing.
// - Exception processing ends as the handler's first op starts.
// - Interrupts, traces, traps, bus and coprocessor errors: exception.
// - Bus or address error during exception processing halts.
// - Halt lasts until external reset is applied.
// - Stop op enters a stopped normal state issuing no bus cycles.
// - Privilege flag clear: user level with user space codes.
// - User level refuses stop, reset and status word writers.
// - Supervisor with task stack select set uses master stack pointer.
// - Supervisor with task stack select clear uses interrupt stack.
// - Reset leaves supervisor interrupt mode, task stack select clear.
// - Task stack select has no effect on privilege checks.
// - Task stack select changes only by status ops, return, interrupts.
// - Interrupt entry saves task stack select, then clears it.
// - Exception processing runs supervisor, supervisor cycles and stack.
// - User level stack references select the user stack pointer.
// - Every data and program access shows supervisor or user on space code lines.
// - Space codes: 1/2 user, 5/6 supervisor, 7 processor space.
// - Exception entry pushes the status word, then sets privilege.
//
// The APB slave port and the placing of the registers were left to the implementer.
module psc_core
    import psc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire psc_instr_t instr_in,
    input wire psc_exc_t exc_in,
    input wire logic bus_pending,
    input wire logic fpu_ext_pending,
    input wire logic handler_start,
    input wire logic [15:0] rte_status,
    input wire logic bus_req,
    input wire psc_acc_t bus_kind,
    output logic instr_accept,
    output logic priv_viol,
    output logic push_valid,
    output logic [15:0] push_data,
    output logic bus_grant,
    output logic [2:0] space_code_lines,
    output psc_sp_t stack_sel,
    output psc_state_t proc_state,
    output logic [15:0] status_word
);

    // ****************************************
    // State registers
    // ****************************************
    psc_state_t state_reg, state_next;
    logic [15:0] status_reg, status_next;
    logic [15:0] saved_reg, saved_next;
    logic run_reg, run_next;
    logic accept_reg, viol_reg, push_reg;
    logic grant_reg;
    logic [2:0] space_reg;
    psc_sp_t sp_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;

    // ****************************************
    // Decode
    // ****************************************
    wire logic sup = status_reg[PSC_PRIV_BIT];
    wire logic tss = status_reg[PSC_TSS_BIT];
    wire logic any_exc = exc_in.irq_ack | exc_in.trace | exc_in.trap |
        exc_in.bus_err | exc_in.addr_err | exc_in.cop_exc;
    wire logic fatal_err = exc_in.bus_err | exc_in.addr_err;
    // Only the privilege flag decides; the stack select bit is not looked at.
    wire logic op_priv = (instr_in.op == PSC_OP_STOP) |
        (instr_in.op == PSC_OP_RESET) | (instr_in.op == PSC_OP_MOVE_SW) |
        (instr_in.op == PSC_OP_ANDI_SW) | (instr_in.op == PSC_OP_EORI_SW) |
        (instr_in.op == PSC_OP_ORI_SW) | (instr_in.op == PSC_OP_RTE);
    wire logic in_normal = state_reg == PSC_ST_NORMAL;
    wire logic take_instr = in_normal & instr_valid & run_reg & ~any_exc;
    wire logic viol = take_instr & op_priv & ~sup;
    wire logic exec = take_instr & ~viol;
    wire logic sync_clear = ~bus_pending & ~fpu_ext_pending;
    wire logic exc_entry = (in_normal | state_reg == PSC_ST_STOPPED) &
        any_exc;
    wire logic enter_exc = exc_entry | viol;
    wire logic irq_entry = exc_entry & exc_in.irq_ack;

    // ****************************************
    // Status word update
    // ****************************************
    logic [15:0] op_status;
    always_comb begin
        case (instr_in.op)
            PSC_OP_MOVE_SW: op_status = instr_in.imm;
            PSC_OP_ANDI_SW: op_status = status_reg & instr_in.imm;
            PSC_OP_EORI_SW: op_status = status_reg ^ instr_in.imm;
            PSC_OP_ORI_SW: op_status = status_reg | instr_in.imm;
            PSC_OP_RTE: op_status = rte_status;
            default: op_status = status_reg;
        endcase
    end

    // Entry forces supervisor after the old word has gone to the stack.
    wire logic [15:0] exc_status = irq_entry ?
        ((status_reg | PSC_PRIV_MASK) & ~PSC_TSS_MASK) :
        (status_reg | PSC_PRIV_MASK);
    assign status_next = enter_exc ? exc_status :
        (exec ? op_status : status_reg);
    assign saved_next = enter_exc ? status_reg : saved_reg;

    // ****************************************
    // Processing state machine
    // ****************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSC_ST_NORMAL: begin
                if (enter_exc) begin
                    state_next = PSC_ST_EXC;
                end else if (exec && instr_in.op == PSC_OP_SYNC) begin
                    state_next = sync_clear ? PSC_ST_NORMAL : PSC_ST_SYNC;
                end else if (exec && instr_in.op == PSC_OP_STOP) begin
                    state_next = PSC_ST_STOPPED;
                end
            end
            PSC_ST_SYNC: begin
                if (sync_clear) begin
                    state_next = PSC_ST_NORMAL;
                end
            end
            PSC_ST_STOPPED: begin
                if (any_exc) begin
                    state_next = PSC_ST_EXC;
                end
            end
            PSC_ST_EXC: begin
                if (fatal_err) begin
                    state_next = PSC_ST_HALTED;
                end else if (handler_start) begin
                    state_next = PSC_ST_NORMAL;
                end
            end
            PSC_ST_HALTED: state_next = PSC_ST_HALTED;
            default: state_next = PSC_ST_HALTED;
        endcase
    end

    // A sync op is accepted only once the earlier traffic has drained.
    wire logic sync_hold = exec & (instr_in.op == PSC_OP_SYNC) & ~sync_clear;
    wire logic accept_next = (exec & ~sync_hold) |
        (state_reg == PSC_ST_SYNC & sync_clear);

    // ****************************************
    // Bus space code and stack choice
    // ****************************************
    wire logic sup_eff = status_next[PSC_PRIV_BIT] |
        (state_next == PSC_ST_EXC);
    wire logic tss_eff = status_next[PSC_TSS_BIT];
    wire logic bus_ok = state_next != PSC_ST_STOPPED &&
        state_next != PSC_ST_HALTED;
    wire logic [2:0] space_next = (bus_kind == PSC_ACC_CPU) ? PSC_SC_CPU :
        (bus_kind == PSC_ACC_PROG) ?
        (sup_eff ? PSC_SC_SUP_PROG : PSC_SC_USER_PROG) :
        (sup_eff ? PSC_SC_SUP_DATA : PSC_SC_USER_DATA);
    wire psc_sp_t sp_next = ~sup_eff ? PSC_SP_USER :
        (tss_eff ? PSC_SP_MASTER : PSC_SP_INTERRUPT);

    // ****************************************
    // APB slave
    // ****************************************
    // Zero wait: data is prepared in setup so every output stays a flop.
    wire logic apb_setup = psel & ~penable;
    wire logic apb_wr = psel & penable & pwrite & pready_reg;
    wire logic hit_status = paddr == PSC_STATUS_OFS;
    wire logic hit_saved = paddr == PSC_SAVED_OFS;
    wire logic hit_state = paddr == PSC_STATE_OFS;
    wire logic hit_ctrl = paddr == PSC_CTRL_OFS;
    wire logic hit_any = hit_status | hit_saved | hit_state | hit_ctrl;
    // Status word is read only here, so software cannot bypass its ops.
    wire logic bad_acc = ~hit_any | (pwrite & ~hit_ctrl);
    wire logic [31:0] rd_mux = hit_status ? {16'h0000, status_reg} :
        hit_saved ? {16'h0000, saved_reg} :
        hit_state ? {24'h000000, sp_reg, tss, sup, 1'h0, state_reg} :
        hit_ctrl ? {31'h00000000, run_reg} : 32'h00000000;
    assign run_next = (apb_wr & hit_ctrl & ~pslverr_reg) ?
        pwdata[PSC_RUN_BIT] : run_reg;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= PSC_ST_EXC;
            status_reg <= PSC_STATUS_RST;
            saved_reg <= 16'h0000;
            run_reg <= PSC_RUN_RST;
            accept_reg <= 1'h0;
            viol_reg <= 1'h0;
            push_reg <= 1'h0;
            grant_reg <= 1'h0;
            space_reg <= PSC_SC_SUP_PROG;
            sp_reg <= PSC_SP_INTERRUPT;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'h0;
            pslverr_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            status_reg <= status_next;
            saved_reg <= saved_next;
            run_reg <= run_next;
            accept_reg <= accept_next;
            viol_reg <= viol;
            push_reg <= enter_exc;
            grant_reg <= bus_req & bus_ok;
            space_reg <= space_next;
            sp_reg <= sp_next;
            prdata_reg <= apb_setup ? rd_mux : prdata_reg;
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup & bad_acc;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign instr_accept = accept_reg;
    assign priv_viol = viol_reg;
    assign push_valid = push_reg;
    assign push_data = saved_reg;
    assign bus_grant = grant_reg;
    assign space_code_lines = space_reg;
    assign stack_sel = sp_reg;
    assign proc_state = state_reg;
    assign status_word = status_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_sync_wait;
        state_reg == PSC_ST_SYNC && (bus_pending || fpu_ext_pending)
            |=> state_reg == PSC_ST_SYNC && !instr_accept;
    endproperty
    a_sync_wait: assert property (p_sync_wait)
        else $error("Sync op left before traffic drained.");

    property p_sync_free;
        state_reg == PSC_ST_SYNC && !bus_pending && !fpu_ext_pending
            |=> state_reg == PSC_ST_NORMAL && instr_accept;
    endproperty
    a_sync_free: assert property (p_sync_free)
        else $error("Sync op did not release once traffic drained.");

    property p_fatal_halt;
        state_reg == PSC_ST_EXC && (exc_in.bus_err || exc_in.addr_err)
            |=> state_reg == PSC_ST_HALTED;
    endproperty
    a_fatal_halt: assert property (p_fatal_halt)
        else $error("Error during exception processing did not halt.");

    property p_halt_stays;
        state_reg == PSC_ST_HALTED |=> state_reg == PSC_ST_HALTED [*2];
    endproperty
    a_halt_stays: assert property (p_halt_stays)
        else $error("Halted state left without reset.");

    property p_stop_quiet;
        state_reg == PSC_ST_STOPPED && !any_exc |=> !bus_grant;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("Bus cycle granted while stopped.");

    property p_reset_mode;
        $rose(rst_n) |-> status_word[PSC_PRIV_BIT] &&
            !status_word[PSC_TSS_BIT] && stack_sel == PSC_SP_INTERRUPT;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("Reset did not leave supervisor interrupt mode.");

    property p_irq_save;
        irq_entry |=> push_valid && push_data == $past(status_reg) &&
            !status_word[PSC_TSS_BIT] && status_word[PSC_PRIV_BIT];
    endproperty
    a_irq_save: assert property (p_irq_save)
        else $error("Interrupt entry did not save and clear stack select.");

    property p_exc_super;
        state_reg == PSC_ST_EXC |-> status_word[PSC_PRIV_BIT];
    endproperty
    a_exc_super: assert property (p_exc_super)
        else $error("Exception processing outside supervisor level.");

    property p_code_legal;
        bus_grant |-> space_code_lines != 3'h0 &&
            space_code_lines != 3'h3 && space_code_lines != 3'h4;
    endproperty
    a_code_legal: assert property (p_code_legal)
        else $error("Reserved space code on a granted bus cycle.");

    property p_user_code;
        !sup_eff && bus_kind != PSC_ACC_CPU |=>
            !space_code_lines[2] && stack_sel == PSC_SP_USER;
    endproperty
    a_user_code: assert property (p_user_code)
        else $error("User level shown as supervisor.");

    property p_viol_trap;
        viol |=> priv_viol && state_reg == PSC_ST_EXC &&
            push_data == $past(status_reg) && !push_data[PSC_PRIV_BIT];
    endproperty
    a_viol_trap: assert property (p_viol_trap)
        else $error("Privileged op at user level was not trapped.");

    property p_exc_entry;
        state_reg == PSC_ST_NORMAL && any_exc |=> state_reg == PSC_ST_EXC;
    endproperty
    a_exc_entry: assert property (p_exc_entry)
        else $error("Exception event did not start exception processing.");

    property p_handler_done;
        state_reg == PSC_ST_EXC && handler_start && !fatal_err |=> in_normal;
    endproperty
    a_handler_done: assert property (p_handler_done)
        else $error("Handler start did not end exception processing.");

    property p_stop_enter;
        exec && instr_in.op == PSC_OP_STOP |=> state_reg == PSC_ST_STOPPED;
    endproperty
    a_stop_enter: assert property (p_stop_enter)
        else $error("Stop op did not enter the stopped state.");

    property p_sup_exec;
        take_instr && op_priv && sup |=> instr_accept && !priv_viol;
    endproperty
    a_sup_exec: assert property (p_sup_exec)
        else $error("Privileged op refused at supervisor level.");

    property p_master_sp;
        sup && tss |-> stack_sel == PSC_SP_MASTER;
    endproperty
    a_master_sp: assert property (p_master_sp)
        else $error("Master stack pointer not selected.");

    property p_irq_sp;
        sup && !tss |-> stack_sel == PSC_SP_INTERRUPT;
    endproperty
    a_irq_sp: assert property (p_irq_sp)
        else $error("Interrupt stack pointer not selected.");

    property p_user_sp;
        !sup |-> stack_sel == PSC_SP_USER;
    endproperty
    a_user_sp: assert property (p_user_sp)
        else $error("User stack pointer not selected.");

    property p_tss_hold;
        !exec && !irq_entry |=> $stable(tss);
    endproperty
    a_tss_hold: assert property (p_tss_hold)
        else $error("Stack select changed without a permitted cause.");

endmodule

// File: hdl/psc_pkg.sv
// Constants and types shared by the processor state and privilege control.
package psc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] PSC_STATUS_OFS = 12'h000;
    localparam logic [11:0] PSC_SAVED_OFS = 12'h004;
    localparam logic [11:0] PSC_STATE_OFS = 12'h008;
    localparam logic [11:0] PSC_CTRL_OFS = 12'h00c;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int PSC_PRIV_BIT = 13;
    localparam int PSC_TSS_BIT = 12;
    localparam logic [15:0] PSC_STATUS_RST = 16'h2000;
    localparam logic [15:0] PSC_PRIV_MASK = 16'h2000;
    localparam logic [15:0] PSC_TSS_MASK = 16'h1000;
    localparam int PSC_RUN_BIT = 0;
    localparam logic PSC_RUN_RST = 1'h1;

    // ****************************************
    // Address space codes
    // ****************************************
    localparam logic [2:0] PSC_SC_USER_DATA = 3'h1;
    localparam logic [2:0] PSC_SC_USER_PROG = 3'h2;
    localparam logic [2:0] PSC_SC_SUP_DATA = 3'h5;
    localparam logic [2:0] PSC_SC_SUP_PROG = 3'h6;
    localparam logic [2:0] PSC_SC_CPU = 3'h7;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        PSC_ST_NORMAL,
        PSC_ST_SYNC,
        PSC_ST_STOPPED,
        PSC_ST_EXC,
        PSC_ST_HALTED
    } psc_state_t;

    typedef enum logic [3:0] {
        PSC_OP_OTHER,
        PSC_OP_SYNC,
        PSC_OP_STOP,
        PSC_OP_RESET,
        PSC_OP_MOVE_SW,
        PSC_OP_ANDI_SW,
        PSC_OP_EORI_SW,
        PSC_OP_ORI_SW,
        PSC_OP_RTE
    } psc_op_t;

    typedef enum logic [1:0] {
        PSC_SP_USER,
        PSC_SP_INTERRUPT,
        PSC_SP_MASTER
    } psc_sp_t;

    typedef enum logic [1:0] {
        PSC_ACC_DATA,
        PSC_ACC_PROG,
        PSC_ACC_CPU
    } psc_acc_t;

    typedef struct packed {
        psc_op_t op;
        logic [15:0] imm;
    } psc_instr_t;

    typedef struct packed {
        logic irq_ack;
        logic trace;
        logic trap;
        logic bus_err;
        logic addr_err;
        logic cop_exc;
    } psc_exc_t;

endpackage

// File: verification/psc_bus_model.sv
// Behavioural model of the memory side answering granted bus cycles.
module psc_bus_model
    import psc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bus_grant,
    input wire logic slow,
    output logic bus_pending
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Cycle tracking
    // ****************************************
    // A slow memory keeps each cycle open for six clocks, so a sync op
    // really has traffic to wait for.
    logic [2:0] busy_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_reg <= 3'h0;
        end else if (bus_grant) begin
            busy_reg <= slow ? 3'h6 : 3'h1;
        end else if (busy_reg != 3'h0) begin
            busy_reg <= busy_reg - 3'h1;
        end
    end
    assign bus_pending = (busy_reg != 3'h0);
endmodule

// File: verification/privilege_state_control_tb.sv
// Self-checking testbench for the processor state and privilege control.
module privilege_state_control_tb
    import psc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Signals
    // ****************************************
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, acc, viol, pv, slow = 0;
    logic instr_valid = 0, fpu_ext_pending = 0, handler_start = 0;
    psc_instr_t instr_in = '0;
    psc_exc_t exc_in = '0;
    logic bus_pending, bus_req = 0, instr_accept, priv_viol, push_valid;
    logic [15:0] rte_status = 0, push_data, pd, status_word, es, im;
    psc_acc_t bus_kind = PSC_ACC_DATA;
    logic bus_grant;
    logic [2:0] space_code_lines;
    psc_sp_t stack_sel;
    psc_state_t proc_state;
    int error_cnt = 0, checks_done = 0, n, i;
    int seed = 32'h75571028;
    psc_op_t rops [5] = '{PSC_OP_MOVE_SW, PSC_OP_ANDI_SW, PSC_OP_EORI_SW,
        PSC_OP_ORI_SW, PSC_OP_RTE};
    psc_op_t pops [7] = '{PSC_OP_STOP, PSC_OP_RESET, PSC_OP_MOVE_SW,
        PSC_OP_ANDI_SW, PSC_OP_EORI_SW, PSC_OP_ORI_SW, PSC_OP_RTE};
    logic [5:0] xs [3] = '{6'h10, 6'h08, 6'h01};

    always #2 ref_clk = ~ref_clk;

    psc_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_in(instr_in), .exc_in(exc_in),
        .bus_pending(bus_pending), .fpu_ext_pending(fpu_ext_pending),
        .handler_start(handler_start), .rte_status(rte_status),
        .bus_req(bus_req), .bus_kind(bus_kind), .instr_accept(instr_accept),
        .priv_viol(priv_viol), .push_valid(push_valid),
        .push_data(push_data), .bus_grant(bus_grant),
        .space_code_lines(space_code_lines), .stack_sel(stack_sel),
        .proc_state(proc_state), .status_word(status_word));
    psc_bus_model mem (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_grant(bus_grant), .slow(slow), .bus_pending(bus_pending));

    // ****************************************
    // Tasks and expectations
    // ****************************************
    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t value %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ins(input psc_op_t op, input logic [15:0] v);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_in <= '{op: op, imm: v};
        rte_status <= v;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        for (n = 0; n < 20; n++) begin
            @(negedge ref_clk);
            acc = instr_accept;
            viol = priv_viol;
            pv = push_valid;
            pd = push_data;
            if (acc === 1'b1 || viol === 1'b1) break;
        end
    endtask
    task automatic exc(input logic [5:0] e);
        @(posedge ref_clk);
        exc_in <= e;
        @(posedge ref_clk);
        exc_in <= '0;
        @(negedge ref_clk);
        pv = push_valid;
        pd = push_data;
    endtask
    task automatic hs();
        @(posedge ref_clk);
        handler_start <= 1'b1;
        @(posedge ref_clk);
        handler_start <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic bus(input psc_acc_t k, input logic g, input logic [2:0] c);
        @(posedge ref_clk);
        bus_req <= 1'b1;
        bus_kind <= k;
        @(posedge ref_clk);
        bus_req <= 1'b0;
        @(negedge ref_clk);
        chk1(bus_grant, g);
        if (g) chkv(32'(space_code_lines), 32'(c));
    endtask
    function automatic logic [15:0] nsw(psc_op_t op, logic [15:0] s,
        logic [15:0] v);
        case (op)
            PSC_OP_ANDI_SW: return s & v;
            PSC_OP_EORI_SW: return s ^ v;
            PSC_OP_ORI_SW: return s | v;
            default: return v;
        endcase
    endfunction
    function automatic logic [15:0] ent(logic [15:0] s, logic irq);
        return (s | PSC_PRIV_MASK) & (irq ? ~PSC_TSS_MASK : 16'hffff);
    endfunction
    function automatic psc_sp_t spx(logic [15:0] s);
        if (!s[PSC_PRIV_BIT]) return PSC_SP_USER;
        return s[PSC_TSS_BIT] ? PSC_SP_MASTER : PSC_SP_INTERRUPT;
    endfunction
    task automatic state_is(input psc_state_t s);
        chkv(32'(proc_state), 32'(s));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        state_is(PSC_ST_EXC);
        chkv(32'(status_word), 32'(PSC_STATUS_RST));
        chkv(32'(stack_sel), 32'(PSC_SP_INTERRUPT));
        ins(PSC_OP_OTHER, 16'h0);
        chk1(acc, 1'b0);
        hs();
        state_is(PSC_ST_NORMAL);
        apb(1'b0, PSC_STATE_OFS, 0);
        chkv(rd, 32'h50);
        apb(1'b0, PSC_CTRL_OFS, 0);
        chkv(rd, 32'h1);
        apb(1'b0, 12'h010, 0);
        chkv({rd[30:0], er}, 32'h1);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, 12'(4 * i), 32'hffff);
            chk1(er, 1'b1);
        end
        apb(1'b0, PSC_STATUS_OFS, 0);
        chkv(rd, 32'(PSC_STATUS_RST));
        apb(1'b1, PSC_CTRL_OFS, 0);
        ins(PSC_OP_OTHER, 16'h0);
        chk1(acc, 1'b0);
        apb(1'b1, PSC_CTRL_OFS, 1);
        bus(PSC_ACC_DATA, 1'b1, 3'h5);
        bus(PSC_ACC_PROG, 1'b1, 3'h6);
        bus(PSC_ACC_CPU, 1'b1, 3'h7);
        es = PSC_STATUS_RST;
        ins(PSC_OP_STOP, 16'h0);
        chk1(acc, 1'b1);
        state_is(PSC_ST_STOPPED);
        bus(PSC_ACC_DATA, 1'b0, 3'h0);
        ins(PSC_OP_MOVE_SW, 16'h3000);
        chk1(acc, 1'b0);
        exc(6'h20);
        chkv({pv, pd}, {1'b1, es});
        hs();
        ins(PSC_OP_MOVE_SW, 16'h3000);
        chkv(32'(stack_sel), 32'(PSC_SP_MASTER));
        exc(6'h20);
        chkv({pv, pd}, 17'h13000);
        chkv(32'(status_word), 32'h2000);
        bus(PSC_ACC_DATA, 1'b1, 3'h5);
        hs();
        // Random status writers; a user result is brought back through an
        // exception, the only path from user up to supervisor.
        es = 16'h2000;
        for (i = 0; i < 8; i++) begin
            im = 16'($random(seed));
            ins(rops[i % 5], im);
            chk1(acc, 1'b1);
            es = nsw(rops[i % 5], es, im);
            chkv(32'(status_word), 32'(es));
            chkv(32'(stack_sel), 32'(spx(es)));
            if (!es[PSC_PRIV_BIT]) begin
                bus(PSC_ACC_DATA, 1'b1, 3'h1);
                bus(PSC_ACC_PROG, 1'b1, 3'h2);
            end
            exc(xs[i % 3]);
            chkv({pv, pd}, {1'b1, es});
            es = ent(es, 1'b0);
            chkv(32'(status_word), 32'(es));
            hs();
        end
        ins(PSC_OP_MOVE_SW, 16'h0);
        ins(PSC_OP_OTHER, 16'h0);
        chk1(acc, 1'b1);
        chkv(32'(stack_sel), 32'(PSC_SP_USER));
        for (i = 0; i < 7; i++) begin
            ins(pops[i], 16'h2000);
            chkv({acc, viol, pv, pd}, 19'h30000);
            state_is(PSC_ST_EXC);
            chkv(32'(status_word), 32'h2000);
            hs();
            ins(PSC_OP_MOVE_SW, 16'h0);
        end
        ins(PSC_OP_SYNC, 16'h0);
        chkv(n, 0);
        slow <= 1'b1;
        bus(PSC_ACC_DATA, 1'b1, 3'h1);
        @(posedge ref_clk);
        fpu_ext_pending <= 1'b1;
        fork
            begin
                repeat (8) @(posedge ref_clk);
                fpu_ext_pending <= 1'b0;
            end
        join_none
        ins(PSC_OP_SYNC, 16'h0);
        chk1(acc === 1'b1 && n > 6, 1'b1);
        for (i = 0; i < 2; i++) begin
            exc(6'h08);
            exc(i ? 6'h02 : 6'h04);
            state_is(PSC_ST_HALTED);
            hs();
            ins(PSC_OP_OTHER, 16'h0);
            chk1(acc, 1'b0);
            state_is(PSC_ST_HALTED);
            @(posedge ref_clk);
            rst_n <= 1'b0;
            repeat (3) @(posedge ref_clk);
            rst_n <= 1'b1;
            @(negedge ref_clk);
            state_is(PSC_ST_EXC);
            chkv(32'(status_word), 32'(PSC_STATUS_RST));
            hs();
        end
        results();
    end
endmodule
